/* src/sddl_pkg.sv */
// Purpose: Shared constants for the serial display driver latch
// Assumes: Twelve-bit serial word, first bit shifted in ends up in the top stage
// Notes: Bit stream crosses from the serial clock into the core clock bit by bit
`default_nettype none
package sddl_pkg;
  localparam int unsigned SDDL_WORD_BITS = 12;
  localparam int unsigned SDDL_FIFO_DEPTH = 4;
  localparam int unsigned SDDL_FIFO_WIDTH = 1;
  localparam logic [11:0] SDDL_WORD_RST = 12'h000;
  localparam logic SDDL_BIT_RST = 1'h0;
  localparam int unsigned SDDL_TOP_STAGE = 11;
endpackage : sddl_pkg
`default_nettype wire

/* src/sddl_fifo.sv */
// Purpose: Dual-clock FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, at least 4
// Notes: Gray pointers cross through two flip-flops each
`default_nettype none
module sddl_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  // Write side
  input wire logic wclk_i,
  input wire logic wrst_i,
  input wire logic wvalid_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic wready_o,
  // Read side
  input wire logic rclk_i,
  input wire logic rrst_i,
  output logic rvalid_o,
  output logic [WIDTH-1:0] rdata_o,
  input wire logic rready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned PW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wbin;
    logic [PW-1:0] wgray;
    logic [PW-1:0] rg_s1;
    logic [PW-1:0] rg_s2;
  } sddl_fw_s;

  typedef struct packed {
    logic [PW-1:0] rbin;
    logic [PW-1:0] rgray;
    logic [PW-1:0] wg_s1;
    logic [PW-1:0] wg_s2;
  } sddl_fr_s;

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  sddl_fw_s w_q, w_d;
  sddl_fr_s r_q, r_d;

  // Full when the write pointer is one lap ahead of the synced read pointer
  assign wready_o = (w_q.wgray != {~w_q.rg_s2[PW-1:PW-2], w_q.rg_s2[PW-3:0]});
  assign rvalid_o = (r_q.rgray != r_q.wg_s2);
  // Entry is stable while it is unread, so reading it across domains is safe
  assign rdata_o = w_q.mem[r_q.rbin[AW-1:0]];

  always_comb begin
    w_d = w_q;
    w_d.rg_s1 = r_q.rgray;
    w_d.rg_s2 = w_q.rg_s1;
    if (wvalid_i && wready_o) begin
      w_d.mem[w_q.wbin[AW-1:0]] = wdata_i;
      w_d.wbin = w_q.wbin + 1'b1;
      w_d.wgray = bin2gray(w_d.wbin);
    end
  end

  always_ff @(posedge wclk_i or posedge wrst_i) begin
    if (wrst_i) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.wg_s1 = w_q.wgray;
    r_d.wg_s2 = r_q.wg_s1;
    if (rvalid_o && rready_i) begin
      r_d.rbin = r_q.rbin + 1'b1;
      r_d.rgray = bin2gray(r_d.rbin);
    end
  end

  always_ff @(posedge rclk_i or posedge rrst_i) begin
    if (rrst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule // sddl_fifo
`default_nettype wire

/* src/sddl_top.sv */
// Purpose: Serial-in shift register, transparent output latch and blanking
// Assumes: Serial clock is a separate domain; load and blank are raw pins
// Notes: Core keeps a mirror of the shift register fed bit by bit through a FIFO
`default_nettype none
module sddl_top (
  // Core clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic sdin_i,
  output logic sdout_o,
  output logic shift_ready_o,
  // Control pins
  input wire logic load_i,
  input wire logic blank_i,
  // Drivers
  output logic [sddl_pkg::SDDL_WORD_BITS-1:0] driver_outputs_o
);
  typedef struct packed {
    logic [sddl_pkg::SDDL_WORD_BITS-1:0] shreg;
  } sddl_link_s;

  typedef struct packed {
    logic load_s1;
    logic load_s2;
    logic blank_s1;
    logic blank_s2;
    logic [sddl_pkg::SDDL_WORD_BITS-1:0] mirror;
    logic [sddl_pkg::SDDL_WORD_BITS-1:0] latch;
    logic [sddl_pkg::SDDL_WORD_BITS-1:0] drv;
  } sddl_core_s;

  sddl_link_s l_q, l_d;
  sddl_core_s c_q, c_d;
  logic bit_valid;
  logic [sddl_pkg::SDDL_FIFO_WIDTH-1:0] bit_data;

  // One shift for both domains, so the core mirror shifts in the same direction as the link register
  function automatic logic [sddl_pkg::SDDL_WORD_BITS-1:0] shift_in(
    input logic [sddl_pkg::SDDL_WORD_BITS-1:0] word,
    input logic bit_in
  );
    return {word[sddl_pkg::SDDL_WORD_BITS-2:0], bit_in};
  endfunction

  // Link domain
  always_comb begin
    l_d = l_q;
    l_d.shreg = shift_in(l_q.shreg, sdin_i);
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      l_q <= '{shreg: sddl_pkg::SDDL_WORD_RST};
    end else begin
      l_q <= l_d;
    end
  end

  assign sdout_o = l_q.shreg[sddl_pkg::SDDL_TOP_STAGE];

  // Every serial edge sends its bit; a full FIFO drops it, so watch shift_ready_o
  // Limitation: the write side only learns of drained bits on serial edges, so a
  // full FIFO with the serial clock stopped stays full; controllers must pace bits
  sddl_fifo #(
    .WIDTH(sddl_pkg::SDDL_FIFO_WIDTH),
    .DEPTH(sddl_pkg::SDDL_FIFO_DEPTH)
  ) u_fifo (
    .wclk_i(sclk_i),
    .wrst_i(rst_i),
    .wvalid_i(1'b1),
    .wdata_i(sdin_i),
    .wready_o(shift_ready_o),
    .rclk_i(clk_i),
    .rrst_i(rst_i),
    .rvalid_o(bit_valid),
    .rdata_o(bit_data),
    .rready_i(1'b1)
  );

  // Core domain
  always_comb begin
    c_d = c_q;
    c_d.load_s1 = load_i;
    c_d.load_s2 = c_q.load_s1;
    c_d.blank_s1 = blank_i;
    c_d.blank_s2 = c_q.blank_s1;
    if (bit_valid) begin
      c_d.mirror = shift_in(c_q.mirror, bit_data[0]);
    end
    if (c_q.load_s2) begin
      c_d.latch = c_d.mirror;
    end else begin
      c_d.latch = c_q.latch;
    end
    if (c_q.blank_s2) begin
      c_d.drv = sddl_pkg::SDDL_WORD_RST;
    end else begin
      c_d.drv = c_d.latch;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_q <= '{load_s1: sddl_pkg::SDDL_BIT_RST,
               load_s2: sddl_pkg::SDDL_BIT_RST,
               blank_s1: sddl_pkg::SDDL_BIT_RST,
               blank_s2: sddl_pkg::SDDL_BIT_RST,
               mirror: sddl_pkg::SDDL_WORD_RST,
               latch: sddl_pkg::SDDL_WORD_RST,
               drv: sddl_pkg::SDDL_WORD_RST};
    end else begin
      c_q <= c_d;
    end
  end

  assign driver_outputs_o = c_q.drv;
endmodule // sddl_top
`default_nettype wire

/* test/sddl_top_sva.sv */
// Purpose: Port checks for sddl_top
// Assumes: Serial clock parked low between words
// Notes: Stage 11 is seen only through sdout_o
`default_nettype none
module sddl_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sdin_i,
  input wire logic sdout_o,
  input wire logic load_i,
  input wire logic blank_i,
  input wire logic [11:0] driver_outputs_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Core cycles since the last serial edge; the mirror settles a few cycles after it
  int unsigned n_shift = 0;
  int unsigned n_shift_seen = 0;
  int unsigned quiet_q = 0;
  always @(posedge sclk_i) begin
    n_shift <= n_shift + 1;
  end
  always @(posedge clk_i) begin
    if (n_shift != n_shift_seen) begin
      n_shift_seen <= n_shift;
      quiet_q <= 0;
    end else if (quiet_q < 15) begin
      quiet_q <= quiet_q + 1;
    end
  end
  a_casc_rise: assert property (@(posedge sclk_i) disable iff (rst_i)
    1 ##12 sdout_o == $past(sdin_i, 12)) else $error("cascade bit");
  a_casc_fall: assert property (@(negedge sclk_i) disable iff (rst_i)
    1 ##11 sdout_o == $past(sdin_i, 11)) else $error("cascade edge");
  a_reset_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> driver_outputs_o == 12'h000 && !sdout_o) else $error("reset value");
  a_blank_force: assert property (@(posedge clk_i) disable iff (rst_i)
    blank_i [*3] |=> driver_outputs_o == 12'h000) else $error("blank");
  a_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    (!blank_i && !load_i) [*4] |=> $stable(driver_outputs_o)) else $error("hold");
  a_follow_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_i && !blank_i && quiet_q >= 8) [*4] |=> $stable(driver_outputs_o)) else $error("follow");
  a_top_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_i && !blank_i && quiet_q >= 8) [*4] |-> driver_outputs_o[11] == sdout_o) else $error("top bit");
  a_blank_late: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(blank_i) ##1 blank_i [*3] |-> driver_outputs_o == 12'h000) else $error("blank late");
  c_blank: cover property (@(posedge clk_i) blank_i [*3]);
  c_load: cover property (@(posedge clk_i) load_i [*8]);
  c_word: cover property (@(posedge sclk_i) sdout_o);
endmodule // sddl_top_sva
bind sddl_top sddl_top_sva u_sddl_top_sva (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
  .sdin_i(sdin_i), .sdout_o(sdout_o), .load_i(load_i), .blank_i(blank_i), .driver_outputs_o(driver_outputs_o));
`default_nettype wire

/* test/sddl_ctl_model.sv */
// Purpose: Serial controller model
// Assumes: One bit per 3 ns pulse
// Notes: Waits on shift_ready_i so no bit is lost
`default_nettype none
module sddl_ctl_model (
  input wire logic shift_ready_i,
  output logic sclk_o,
  output logic sdin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Gap after each pulse lets the core drain the bit before the next serial edge
  localparam int BIT_GAP_NS = 200;
  initial begin
    sclk_o = 1'h0;
    sdin_o = 1'h0;
  end
  task automatic send_word(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      while (shift_ready_i !== 1'h1) #3;
      sdin_o = w[i];
      #3 sclk_o = 1'h1;
      #3 sclk_o = 1'h0;
      #BIT_GAP_NS;
    end
    #3 sdin_o = ~w[0];
  endtask
endmodule // sddl_ctl_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for sddl_top
// Assumes: Controller model paces the serial clock
// Notes: Fixed waits cover sync latency only
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic load_i = 1'h0;
  logic blank_i = 1'h0;
  wire logic sclk_i, sdin_i, sdout_o, shift_ready_o;
  wire logic [11:0] driver_outputs_o;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 clk_i = ~clk_i;
  sddl_top u_sddl_top (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sdin_i(sdin_i), .sdout_o(sdout_o),
    .shift_ready_o(shift_ready_o), .load_i(load_i), .blank_i(blank_i), .driver_outputs_o(driver_outputs_o));
  sddl_ctl_model u_sddl_ctl_model (.shift_ready_i(shift_ready_o), .sclk_o(sclk_i), .sdin_o(sdin_i));
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pins(input logic l, input logic b);
    @(posedge clk_i);
    #1 load_i = l;
    blank_i = b;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic t_reset();
    chk("drivers", driver_outputs_o, 12'h000);
    chk("cascade", {11'h000, sdout_o}, 12'h000);
    chk("ready", {11'h000, shift_ready_o}, 12'h001);
  endtask
  task automatic t_load_word();
    u_sddl_ctl_model.send_word(12'ha5c);
    pins(1'h0, 1'h0);
    chk("drivers", driver_outputs_o, 12'h000);
    pins(1'h1, 1'h0);
    chk("drivers", driver_outputs_o, 12'ha5c);
    chk("cascade", {11'h000, sdout_o}, 12'h001);
    chk("ready", {11'h000, shift_ready_o}, 12'h001);
  endtask
  task automatic t_hold_blank();
    pins(1'h0, 1'h1);
    chk("drivers", driver_outputs_o, 12'h000);
    u_sddl_ctl_model.send_word(12'h3c3);
    pins(1'h0, 1'h0);
    chk("drivers", driver_outputs_o, 12'ha5c);
    pins(1'h1, 1'h0);
    chk("drivers", driver_outputs_o, 12'h3c3);
  endtask
  task automatic t_mid_reset();
    @(posedge clk_i);
    #1 rst_i = 1'h1;
    @(posedge clk_i);
    chk("drivers", driver_outputs_o, 12'h000);
    #1 rst_i = 1'h0;
    repeat (8) @(posedge clk_i);
    chk("drivers", driver_outputs_o, 12'h000);
    chk("cascade", {11'h000, sdout_o}, 12'h000);
    chk("ready", {11'h000, shift_ready_o}, 12'h001);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'h0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_load_word();
    t_hold_blank();
    t_mid_reset();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
